//--- inc/sbsr_pkg.sv
package sbsr_pkg;
	localparam int SUMMARY_WIDTH   = 8;
	localparam int LOW_WIDTH       = 16;
	localparam int BIT_UNUSED0     = 0;
	localparam int BIT_UNUSED1     = 1;
	localparam int BIT_ERRQ        = 2;
	localparam int BIT_QUES        = 3;
	localparam int BIT_MSG         = 4;
	localparam int BIT_STDEV       = 5;
	localparam int BIT_MASTER      = 6;
	localparam int BIT_OPER        = 7;
	localparam logic [7:0] MASK_RESET  = 8'h00;
	localparam logic [7:0] STDEV_RESET = 8'h00;
	localparam logic [15:0] ENAB_RESET = 16'h0000;
	localparam logic [15:0] EVENT_RESET = 16'h0000;

	typedef enum logic [2:0] {
		REG_SUMMARY  = 3'b000,
		REG_SRQMASK  = 3'b001,
		REG_STDEVENT = 3'b010,
		REG_STDMASK  = 3'b011,
		REG_QUES  = 3'b100,
		REG_QENAB = 3'b101,
		REG_OPER  = 3'b110,
		REG_OENAB = 3'b111
	} sbsr_sel_e;
endpackage : sbsr_pkg

//--- verilog/sbsr_event_reg.sv
module sbsr_event_reg #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             clkEn,
	// Event sources
	input  wire logic [WIDTH-1:0] eventSet,
	// Enable write
	input  wire logic             enabWr,
	input  wire logic [WIDTH-1:0] enabData,
	// Destructive read
	input  wire logic             eventRd,
	// State
	output logic      [WIDTH-1:0] eventQ,
	output logic      [WIDTH-1:0] enabQ,
	output logic                  sumBit
);
	initial begin
		if (WIDTH < 1 || WIDTH > 16) $error("sbsr_event_reg: WIDTH out of range");
	end

	// Set beats the read clear so no event is lost
	// (R15) read clears event
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			eventQ <= '0;
		end else if (clkEn) begin
			eventQ <= (eventRd ? '0 : eventQ) | eventSet;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			enabQ <= '0;
		end else if (clkEn && enabWr) begin
			enabQ <= enabData;
		end
	end

	// (R14) OR of event AND enable
	assign sumBit = |(eventQ & enabQ);
endmodule : sbsr_event_reg

//--- verilog/sbsr_status_byte.sv
// Summary of operation
// (R1) Bit 6 is master summary: any other enabled status bit set.
// (R2) One mask bit per status bit; mask bit 6 ignored.
// (R3) Service request raised when an enabled status bit rises 0 to 1.
// (R4) Bit 2 set when a new error enters the error queue.
// (R5) With bit 2 enabled, each new error entry raises a request.
// (R6) Bit 3 is questionable register enabled-event summary.
// (R7) Bit 4 follows output buffer message waiting.
// (R8) Bit 5 is standard event register enabled summary.
// (R9) Bit 7 is operation register enabled-event summary.
// (R10) Each status position pairs with mask position of same index.
// (R11) Status byte returned by query and serial poll alike.
// (R12) Mask written by enable command and read back unchanged.
// (R13) Controller should enable bit 2 and read errors after requests.
// (R14) Lower summaries are OR of event AND enable bits.
// (R15) Reading a lower event register clears it.
// (R16) Bits 0 and 1 read zero and never feed summary.
// (R17) Request held until no enabled bit set, then dropped next cycle; code also drops it one cycle on an error push while raised with mask bit 2 set.
module sbsr_status_byte #(
	parameter int QUES_WIDTH = 16,
	parameter int OPER_WIDTH = 16
) (
	// Clock, reset, enable
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clkEn,
	// Status sources
	input  wire logic                  errQueueNotEmpty,
	input  wire logic                  errQueuePush,
	input  wire logic                  outputMessageWaiting,
	input  wire logic [7:0]            standardEventSet,
	input  wire logic [QUES_WIDTH-1:0] quesEventSet,
	input  wire logic [OPER_WIDTH-1:0] operEventSet,
	// Register access port
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	input  wire logic [2:0]            regSel,
	input  wire logic [15:0]           regWrData,
	output logic      [15:0]           regRdData,
	// Serial poll
	input  wire logic                  serialPoll,
	output logic      [7:0]            pollData,
	// Summary outputs
	output logic      [7:0]            statusSummaryByte,
	output logic                       masterSummaryFlag,
	output logic                       serviceRequest
);
	initial begin
		if (QUES_WIDTH < 1 || QUES_WIDTH > sbsr_pkg::LOW_WIDTH) $error("QUES_WIDTH bad");
		if (OPER_WIDTH < 1 || OPER_WIDTH > sbsr_pkg::LOW_WIDTH) $error("OPER_WIDTH bad");
	end

	logic [7:0]            serviceRequestMask_q;
	logic [7:0]            standardEventRegister_q;
	logic [7:0]            standardEventMask_q;
	logic [QUES_WIDTH-1:0] quesEvent;
	logic [QUES_WIDTH-1:0] quesEnab;
	logic [OPER_WIDTH-1:0] operEvent;
	logic [OPER_WIDTH-1:0] operEnab;
	logic                  quesSum;
	logic                  operSum;
	logic                  standardEventSummary;
	logic [7:0]            coreBits;
	logic [7:0]            enabledBits;
	logic [7:0]            risingEnabled;
	logic [7:0]            prevCore_q;
	logic                  errPulse_q;
	logic                  srq_q;
	logic                  wrSel;

	function automatic logic isAccess(input logic en, input logic [2:0] sel,
			input sbsr_pkg::sbsr_sel_e want);
		isAccess = en && (sel == want);
	endfunction : isAccess

	// (R15) questionable read clears
	sbsr_event_reg #(.WIDTH(QUES_WIDTH)) quesReg (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clkEn    (clkEn),
		.eventSet (quesEventSet),
		.enabWr   (isAccess(regWr, regSel, sbsr_pkg::REG_QENAB)),
		.enabData (regWrData[QUES_WIDTH-1:0]),
		.eventRd  (isAccess(regRd, regSel, sbsr_pkg::REG_QUES)),
		.eventQ   (quesEvent),
		.enabQ    (quesEnab),
		.sumBit   (quesSum)
	);

	// (R15) operation read clears
	sbsr_event_reg #(.WIDTH(OPER_WIDTH)) operReg (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clkEn    (clkEn),
		.eventSet (operEventSet),
		.enabWr   (isAccess(regWr, regSel, sbsr_pkg::REG_OENAB)),
		.enabData (regWrData[OPER_WIDTH-1:0]),
		.eventRd  (isAccess(regRd, regSel, sbsr_pkg::REG_OPER)),
		.eventQ   (operEvent),
		.enabQ    (operEnab),
		.sumBit   (operSum)
	);

	// (R15) standard event read clears, set wins
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			standardEventRegister_q <= sbsr_pkg::STDEV_RESET;
		end else if (clkEn) begin
			standardEventRegister_q <= (isAccess(regRd, regSel, sbsr_pkg::REG_STDEVENT)
				? 8'h00 : standardEventRegister_q) | standardEventSet;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			standardEventMask_q <= sbsr_pkg::STDEV_RESET;
		end else if (clkEn && isAccess(regWr, regSel, sbsr_pkg::REG_STDMASK)) begin
			standardEventMask_q <= regWrData[7:0];
		end
	end

	// (R12) mask stored as written
	assign wrSel = isAccess(regWr, regSel, sbsr_pkg::REG_SRQMASK);
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			serviceRequestMask_q <= sbsr_pkg::MASK_RESET;
		end else if (clkEn && wrSel) begin
			serviceRequestMask_q <= regWrData[7:0];
		end
	end

	// (R8) standard event summary
	assign standardEventSummary = |(standardEventRegister_q & standardEventMask_q);

	// Status byte without bit 6
	always_comb begin
		coreBits = 8'h00;
		// (R16) bits 0 and 1 zero
		coreBits[sbsr_pkg::BIT_UNUSED0] = 1'b0;
		coreBits[sbsr_pkg::BIT_UNUSED1] = 1'b0;
		// (R4) error queue not empty or error push this cycle
		coreBits[sbsr_pkg::BIT_ERRQ] = errQueueNotEmpty | errQueuePush;
		// (R6) questionable summary
		coreBits[sbsr_pkg::BIT_QUES] = quesSum;
		// (R7) message waiting
		coreBits[sbsr_pkg::BIT_MSG] = outputMessageWaiting;
		coreBits[sbsr_pkg::BIT_STDEV] = standardEventSummary;
		// (R9) operation summary
		coreBits[sbsr_pkg::BIT_OPER] = operSum;
	end

	// (R2) mask bit 6 dropped; (R10) same-index pairing
	always_comb begin
		enabledBits = coreBits & serviceRequestMask_q;
		enabledBits[sbsr_pkg::BIT_MASTER] = 1'b0;
	end

	// (R1) master summary
	assign masterSummaryFlag = |enabledBits;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prevCore_q <= 8'h00;
			errPulse_q <= 1'b0;
		end else if (clkEn) begin
			prevCore_q <= coreBits;
			errPulse_q <= errQueuePush;
		end
	end

	// (R3) rising enabled bit; (R5) every error push counts as a rise
	always_comb begin
		risingEnabled = coreBits & ~prevCore_q & serviceRequestMask_q;
		risingEnabled[sbsr_pkg::BIT_ERRQ] = serviceRequestMask_q[sbsr_pkg::BIT_ERRQ]
			& (errQueuePush | (coreBits[sbsr_pkg::BIT_ERRQ] & ~prevCore_q[sbsr_pkg::BIT_ERRQ]));
		risingEnabled[sbsr_pkg::BIT_MASTER] = 1'b0;
	end

	// Request drops for one cycle on a push while raised, then comes back,
	// so each push is seen as a separate request edge.
	// (R17) held until nothing enabled
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			srq_q <= 1'b0;
		end else if (clkEn) begin
			if (srq_q && errQueuePush && serviceRequestMask_q[sbsr_pkg::BIT_ERRQ]) begin
				srq_q <= 1'b0;
			end else if (|risingEnabled || (errPulse_q && !srq_q
					&& serviceRequestMask_q[sbsr_pkg::BIT_ERRQ])) begin
				srq_q <= 1'b1;
			end else if (!masterSummaryFlag) begin
				srq_q <= 1'b0;
			end
		end
	end
	assign serviceRequest = srq_q;

	// Status byte register, bit 6 from summary
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			statusSummaryByte <= 8'h00;
		end else if (clkEn) begin
			statusSummaryByte <= coreBits | ({7'h00, masterSummaryFlag} << sbsr_pkg::BIT_MASTER);
		end
	end

	// (R11) serial poll returns current byte
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pollData <= 8'h00;
		end else if (clkEn && serialPoll) begin
			pollData <= coreBits | ({7'h00, masterSummaryFlag} << sbsr_pkg::BIT_MASTER);
		end
	end

	// (R11) query path; (R12) mask readback
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			regRdData <= 16'h0000;
		end else if (clkEn && regRd) begin
			unique case (sbsr_pkg::sbsr_sel_e'(regSel))
				sbsr_pkg::REG_SUMMARY:  regRdData <= {8'h00, coreBits
					| ({7'h00, masterSummaryFlag} << sbsr_pkg::BIT_MASTER)};
				sbsr_pkg::REG_SRQMASK:  regRdData <= {8'h00, serviceRequestMask_q};
				sbsr_pkg::REG_STDEVENT: regRdData <= {8'h00, standardEventRegister_q};
				sbsr_pkg::REG_STDMASK:  regRdData <= {8'h00, standardEventMask_q};
				sbsr_pkg::REG_QUES:  regRdData <= 16'(quesEvent);
				sbsr_pkg::REG_QENAB: regRdData <= 16'(quesEnab);
				sbsr_pkg::REG_OPER:  regRdData <= 16'(operEvent);
				sbsr_pkg::REG_OENAB: regRdData <= 16'(operEnab);
			endcase
		end
	end
endmodule : sbsr_status_byte

//--- verification/sbsr_status_byte_checker.sv
module sbsr_status_byte_checker (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic        clkEn,
	// Watched ports
	input wire logic        errQueuePush,
	input wire logic        outputMessageWaiting,
	input wire logic        regRd,
	input wire logic [2:0]  regSel,
	input wire logic [15:0] regRdData,
	input wire logic        serialPoll,
	input wire logic [7:0]  pollData,
	input wire logic [7:0]  statusSummaryByte,
	input wire logic        masterSummaryFlag,
	input wire logic        serviceRequest
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	// Frozen cycles carry no meaning
	default disable iff (sys_rst || !clkEn);
	property p_lowZero; statusSummaryByte[1:0] == 2'h0; endproperty
	a_lowZero: assert property (p_lowZero) else $error("unused bits set");
	property p_msg; 1 |=> statusSummaryByte[4] == $past(outputMessageWaiting); endproperty
	a_msg: assert property (p_msg) else $error("message bit wrong");
	property p_err; errQueuePush |=> statusSummaryByte[2]; endproperty
	a_err: assert property (p_err) else $error("error bit missing");
	property p_mss; 1 |=> statusSummaryByte[6] == $past(masterSummaryFlag); endproperty
	a_mss: assert property (p_mss) else $error("summary bit wrong");
	property p_mssCause; statusSummaryByte[6] |-> (statusSummaryByte & 8'hBC) != 8'h00; endproperty
	a_mssCause: assert property (p_mssCause) else $error("summary without cause");
	property p_srqRise; $rose(masterSummaryFlag) |=> serviceRequest; endproperty
	a_srqRise: assert property (p_srqRise) else $error("request missing");
	property p_srqDrop; !masterSummaryFlag |=> !serviceRequest; endproperty
	a_srqDrop: assert property (p_srqDrop) else $error("request kept");
	property p_poll; serialPoll ##1 $stable(statusSummaryByte) |-> pollData == statusSummaryByte;
	endproperty
	a_poll: assert property (p_poll) else $error("poll data wrong");
	property p_rdHold; !regRd |=> $stable(regRdData); endproperty
	a_rdHold: assert property (p_rdHold) else $error("read data moved");
endmodule : sbsr_status_byte_checker

//--- verification/sbsr_ctrl_model.sv
module sbsr_ctrl_model (
	// Clock
	input wire logic        ref_clk,
	// Register access
	output logic            regWr,
	output logic            regRd,
	output logic [2:0]      regSel,
	output logic [15:0]     regWrData,
	input wire logic [15:0] regRdData,
	// Serial poll
	output logic            serialPoll,
	input wire logic [7:0]  pollData
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		regWr = 1'b0;
		regRd = 1'b0;
		serialPoll = 1'b0;
		regSel = 3'h0;
		regWrData = 16'h0000;
	end
	task automatic wrReg(input logic [2:0] sel, input logic [15:0] data);
		@(negedge ref_clk);
		regSel = sel;
		regWrData = data;
		regWr = 1'b1;
		@(negedge ref_clk);
		regWr = 1'b0;
		// Released data is not left looking valid
		regWrData = ~data;
	endtask : wrReg
	task automatic rdReg(input logic [2:0] sel, output logic [15:0] data);
		@(negedge ref_clk);
		regSel = sel;
		regRd = 1'b1;
		@(negedge ref_clk);
		regRd = 1'b0;
		data = regRdData;
	endtask : rdReg
	task automatic poll(output logic [7:0] data);
		@(negedge ref_clk);
		serialPoll = 1'b1;
		@(negedge ref_clk);
		serialPoll = 1'b0;
		data = pollData;
	endtask : poll
endmodule : sbsr_ctrl_model

//--- verification/sbsr_status_byte_test.sv
module sbsr_status_byte_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        ref_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        errQueueNotEmpty = 1'b0;
	logic        errQueuePush = 1'b0;
	logic        outputMessageWaiting = 1'b0;
	logic [7:0]  standardEventSet = 8'h00;
	logic [15:0] quesEventSet = 16'h0000;
	logic [15:0] operEventSet = 16'h0000;
	logic        regWr, regRd, serialPoll, masterSummaryFlag, serviceRequest, srqLast;
	logic [2:0]  regSel;
	logic [15:0] regWrData, regRdData, rd;
	logic [7:0]  pollData, statusSummaryByte, pd;
	int          errCount = 0;
	int          comparisons = 0;
	int          srqRises = 0;
	initial forever #10 ref_clk = ~ref_clk;
	always @(negedge ref_clk) begin
		if (serviceRequest === 1'b1 && srqLast !== 1'b1) srqRises++;
		srqLast = serviceRequest;
	end
	sbsr_status_byte u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(1'b1),
		.errQueueNotEmpty(errQueueNotEmpty), .errQueuePush(errQueuePush),
		.outputMessageWaiting(outputMessageWaiting), .standardEventSet(standardEventSet),
		.quesEventSet(quesEventSet), .operEventSet(operEventSet), .regWr(regWr),
		.regRd(regRd), .regSel(regSel), .regWrData(regWrData), .regRdData(regRdData),
		.serialPoll(serialPoll), .pollData(pollData), .statusSummaryByte(statusSummaryByte),
		.masterSummaryFlag(masterSummaryFlag), .serviceRequest(serviceRequest));
	sbsr_ctrl_model u_ctrl (.ref_clk(ref_clk), .regWr(regWr), .regRd(regRd),
		.regSel(regSel), .regWrData(regWrData), .regRdData(regRdData),
		.serialPoll(serialPoll), .pollData(pollData));
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
		comparisons++;
		if (seen !== want) begin
			errCount++;
			$display("[ERR] %0t %s seen %h want %h", $time, what, seen, want);
		end
	endtask : check
	task automatic stopTest;
		$display("comparisons %0d mismatches %0d", comparisons, errCount);
		if (errCount == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : stopTest
	task automatic t_mask;
		check({8'h00, statusSummaryByte}, 16'h0000, "status reset");
		u_ctrl.rdReg(3'h1, rd);
		check(rd, {8'h00, sbsr_pkg::MASK_RESET}, "mask reset");
		// Status byte itself is read-only
		u_ctrl.wrReg(3'h0, 16'hFFFF);
		u_ctrl.wrReg(3'h1, 16'hFFFF);
		u_ctrl.rdReg(3'h1, rd);
		check(rd, 16'h00FF, "mask readback");
		u_ctrl.wrReg(3'h1, 16'h0040);
		outputMessageWaiting = 1'b1;
		cyc(3);
		check({8'h00, statusSummaryByte}, 16'h0010, "mask bit6 status");
		check({15'h0000, serviceRequest}, 16'h0000, "mask bit6 srq");
		outputMessageWaiting = 1'b0;
		cyc(2);
		$display("t_mask done");
	endtask : t_mask
	task automatic t_msg;
		u_ctrl.wrReg(3'h1, 16'h0010);
		outputMessageWaiting = 1'b1;
		cyc(2);
		check({8'h00, statusSummaryByte}, 16'h0050, "message status");
		check({15'h0000, serviceRequest}, 16'h0001, "message srq");
		u_ctrl.poll(pd);
		check({8'h00, pd}, 16'h0050, "poll");
		u_ctrl.rdReg(3'h0, rd);
		check(rd, 16'h0050, "status query");
		outputMessageWaiting = 1'b0;
		cyc(2);
		check({8'h00, statusSummaryByte}, 16'h0000, "message clear");
		check({15'h0000, serviceRequest}, 16'h0000, "srq drop");
		$display("t_msg done");
	endtask : t_msg
	task automatic t_err;
		u_ctrl.wrReg(3'h1, 16'h0004);
		srqRises = 0;
		for (int i = 0; i < 2; i++) begin
			errQueuePush = 1'b1;
			errQueueNotEmpty = 1'b1;
			cyc(1);
			errQueuePush = 1'b0;
			cyc(3);
			check({8'h00, statusSummaryByte}, 16'h0044, "err status");
		end
		check(16'(srqRises), 16'h0002, "one request per entry");
		errQueueNotEmpty = 1'b0;
		cyc(2);
		check({15'h0000, serviceRequest}, 16'h0000, "err srq drop");
		$display("t_err done");
	endtask : t_err
	task automatic pulse(input int k, input logic [15:0] v);
		standardEventSet = (k == 0) ? v[7:0] : 8'h00;
		quesEventSet = (k == 1) ? v : 16'h0000;
		operEventSet = (k == 2) ? v : 16'h0000;
		cyc(1);
		standardEventSet = 8'h00;
		quesEventSet = 16'h0000;
		operEventSet = 16'h0000;
	endtask : pulse
	task automatic t_lower;
		logic [2:0]  evSel [3] = '{3'h2, 3'h4, 3'h6};
		logic [15:0] want [3] = '{16'h0060, 16'h0048, 16'h00C0};
		u_ctrl.wrReg(3'h1, 16'h00A8);
		for (int i = 0; i < 3; i++) begin
			u_ctrl.wrReg(evSel[i] + 3'h1, 16'h0001);
			pulse(i, 16'h0002);
			cyc(3);
			check({8'h00, statusSummaryByte}, 16'h0000, "unenabled event");
			pulse(i, 16'h0001);
			cyc(3);
			check({8'h00, statusSummaryByte}, want[i], "lower summary");
			u_ctrl.rdReg(evSel[i], rd);
			check(rd, 16'h0003, "event read");
			cyc(3);
			check({8'h00, statusSummaryByte}, 16'h0000, "read clears");
		end
		$display("t_lower done");
	endtask : t_lower
	initial begin
		cyc(20);
		sys_rst = 1'b0;
		cyc(2);
		t_mask();
		t_msg();
		t_err();
		t_lower();
		stopTest();
	end
	// Guard against a hung run
	initial begin
		repeat (5000) @(posedge ref_clk);
		errCount++;
		stopTest();
	end
endmodule : sbsr_status_byte_test
bind sbsr_status_byte sbsr_status_byte_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.clkEn(clkEn), .errQueuePush(errQueuePush), .outputMessageWaiting(outputMessageWaiting),
	.regRd(regRd), .regSel(regSel), .regRdData(regRdData), .serialPoll(serialPoll),
	.pollData(pollData), .statusSummaryByte(statusSummaryByte),
	.masterSummaryFlag(masterSummaryFlag), .serviceRequest(serviceRequest));
